/* File: i2c_bus_peer.sv */
// far-side bus party: acking slave, or a master at an 800 ns bit period
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_peer (
	// design enables, low pulls the line
	input wire logic	dut_scl_oe_n,
	input wire logic	dut_sda_oe_n,
	// resolved levels
	output logic	scl,
	output logic	sda
);
	logic	m_scl = 1'b1, m_sda = 1'b1, pull = 1'b0, drv = 1'b0, ack = 1'b1;
	logic [7:0]	sr, got;
	int	nb = 0;
	// released lines float high through the pull-ups
	assign scl = dut_scl_oe_n & m_scl;
	assign sda = dut_sda_oe_n & m_sda & !pull;
	always @(negedge sda) if (scl && !drv) nb = 0;
	always @(posedge scl) begin
		if (!drv) begin
			sr = {sr[6:0], sda};
			nb++;
			if (nb % 9 == 8) got = sr;
		end
	end
	// ack slot set on the falling edge so it is settled before the ninth clock
	always @(negedge scl) if (!drv) pull <= ack && nb % 9 == 8;
	task automatic xfer(input logic [7:0] b, output logic a);
		drv = 1'b1;
		m_sda = 1'b0;
		#400 m_scl = 1'b0;
		for (int i = 8; i >= 0; i--) begin
			#100 m_sda = i > 0 ? b[i - 1] : 1'b1;
			#300 m_scl = 1'b1;
			#200 a = !sda;
			#200 m_scl = 1'b0;
		end
	endtask
	task automatic stop(output logic ok);
		int n;
		#100 m_sda = 1'b0;
		#300 m_scl = 1'b1;
		for (n = 0; n < 100 && !scl; n++) #100;
		ok = scl;
		#400 m_sda = 1'b1;
		#400 drv = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: i2c_ctrl_monitor.sv */
// port checker for the two-wire controller
`timescale 1ns/100ps
`default_nettype none
module i2c_ctrl_monitor (
	// clock
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic	ce,
	// register bus
	input wire logic	awvalid,
	input wire logic	awready,
	input wire logic	bvalid,
	input wire logic	bready,
	input wire logic	arvalid,
	input wire logic	arready,
	input wire logic [4:0]	araddr,
	input wire logic	rvalid,
	input wire logic	rready,
	input wire logic [31:0]	rdata,
	input wire logic [1:0]	rresp,
	// pins and power
	input wire logic	scl_out,
	input wire logic	sda_out,
	input wire logic	sleep_mode,
	input wire logic	wake_req
);
	// a frozen clock enable stalls every sequence, so it counts as reset here
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	AST_W_ANSWER: assert property (awvalid && awready |=> !awready ##1 bvalid) else $error("late write answer");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid) else $error("write answer dropped");
	AST_R_ANSWER: assert property (arvalid && arready |=> !arready ##1 rvalid) else $error("late read answer");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
	AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
	AST_UNMAPPED: assert property (arvalid && arready && araddr > 5'h18 |-> ##2 rresp == 2'b10 && rdata == 0)
		else $error("unmapped read not refused");
	AST_OPEN_DRAIN: assert property (!scl_out && !sda_out) else $error("pin driven high");
	AST_WAKE_DROP: assert property ($fell(sleep_mode) |=> !wake_req) else $error("wake kept after sleep");
endmodule
bind i2c_master_slave_ctrl i2c_ctrl_monitor i_mon (.aclk, .aresetn, .ce, .awvalid, .awready, .bvalid, .bready,
	.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .scl_out, .sda_out, .sleep_mode, .wake_req);
`default_nettype wire

/* File: i2c_ctrl_pkg.sv */
// constants, register map and status codes of the two-wire bus controller
package i2c_ctrl_pkg;
	localparam int         AXI_AW     = 5;
	localparam logic [4:0] ADDR_CTRL  = 5'h00;
	localparam logic [4:0] ADDR_STAT  = 5'h04;
	localparam logic [4:0] ADDR_DATA  = 5'h08;
	localparam logic [4:0] ADDR_OWN   = 5'h0C;
	localparam logic [4:0] ADDR_ISTS  = 5'h10;
	localparam logic [4:0] ADDR_IMSK  = 5'h14;
	localparam logic [4:0] ADDR_HALF  = 5'h18;
	localparam logic [4:0] ADDR_LAST  = 5'h18;
	// bus_control field positions
	localparam int         CTL_FLAG   = 7;
	localparam int         CTL_ACK    = 6;
	localparam int         CTL_START  = 5;
	localparam int         CTL_STOP   = 4;
	localparam int         CTL_WCOL   = 3;
	localparam int         CTL_EN     = 2;
	localparam int         CTL_IE     = 0;
	// irq_status / irq_mask field positions
	localparam int         IRQ_DONE   = 0;
	localparam int         IRQ_WCOL   = 1;
	localparam int         IRQ_WAKE   = 2;
	localparam int         IRQ_ARB    = 3;
	// reset values
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] OWN_RST    = 8'h00;
	localparam logic [7:0] DATA_RST   = 8'hFF;
	localparam logic [3:0] IMSK_RST   = 4'h0;
	localparam logic [7:0] HALF_RST   = 8'h04;
	// status codes
	localparam logic [7:0] ST_START   = 8'h08;
	localparam logic [7:0] ST_RSTART  = 8'h10;
	localparam logic [7:0] ST_AW_ACK  = 8'h18;
	localparam logic [7:0] ST_AW_NACK = 8'h20;
	localparam logic [7:0] ST_DW_ACK  = 8'h28;
	localparam logic [7:0] ST_DW_NACK = 8'h30;
	localparam logic [7:0] ST_ARB     = 8'h38;
	localparam logic [7:0] ST_AR_ACK  = 8'h40;
	localparam logic [7:0] ST_AR_NACK = 8'h48;
	localparam logic [7:0] ST_DR_ACK  = 8'h50;
	localparam logic [7:0] ST_DR_NACK = 8'h58;
	localparam logic [7:0] ST_SW      = 8'h60;
	localparam logic [7:0] ST_SW_ARB  = 8'h68;
	localparam logic [7:0] ST_GC      = 8'h70;
	localparam logic [7:0] ST_GC_ARB  = 8'h78;
	localparam logic [7:0] ST_SR_ACK  = 8'h80;
	localparam logic [7:0] ST_SR_NACK = 8'h88;
	localparam logic [7:0] ST_GR_ACK  = 8'h90;
	localparam logic [7:0] ST_GR_NACK = 8'h98;
	localparam logic [7:0] ST_SR_STOP = 8'hA0;
	localparam logic [7:0] ST_SR      = 8'hA8;
	localparam logic [7:0] ST_SR_ARB  = 8'hB0;
	localparam logic [7:0] ST_ST_ACK  = 8'hB8;
	localparam logic [7:0] ST_ST_NACK = 8'hC0;
	localparam logic [7:0] ST_ST_LAST = 8'hC8;
	localparam logic [7:0] ST_NONE    = 8'hF8;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLV   = 2'b10;
endpackage

/* File: i2c_master_slave_ctrl.sv */
// two-wire bus controller: master and slave sequencing behind an axi4-lite slave
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_slave_ctrl (
	// clock, reset, enable
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	input  wire logic                             ce,
	// axi4-lite write
	input  wire logic [i2c_ctrl_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                             awvalid,
	output var  logic                             awready,
	input  wire logic [31:0]                      wdata,
	input  wire logic [3:0]                       wstrb,
	input  wire logic                             wvalid,
	output var  logic                             wready,
	output var  logic [1:0]                       bresp,
	output var  logic                             bvalid,
	input  wire logic                             bready,
	// axi4-lite read
	input  wire logic [i2c_ctrl_pkg::AXI_AW-1:0] araddr,
	input  wire logic                             arvalid,
	output var  logic                             arready,
	output var  logic [31:0]                      rdata,
	output var  logic [1:0]                       rresp,
	output var  logic                             rvalid,
	input  wire logic                             rready,
	// bus pins, open drain
	input  wire logic                             scl_in,
	output var  logic                             scl_out,
	output var  logic                             scl_oe_n,
	input  wire logic                             sda_in,
	output var  logic                             sda_out,
	output var  logic                             sda_oe_n,
	// power and interrupt
	input  wire logic                             sleep_mode,
	output var  logic                             wake_req,
	output var  logic                             irq
);
	typedef enum logic [2:0] {st_idle, st_start, st_rstart, st_low, st_high, st_hold, st_stop} mst_state_e;

	mst_state_e  state;
	logic [1:0]  pin_s;
	logic        scl_s, sda_s, scl_q, sda_q;
	logic        scl_rise, scl_fall, start_det, stop_det;
	logic        flag, ack_en, start_req, stop_req, wcol, enable, irq_en;
	logic [7:0]  own_addr, data, status, half, tmr, m_code, s_code;
	logic [3:0]  irq_sts, irq_mask, irq_ev, bit_cnt, mon_cnt;
	logic [4:0]  aw_q, ar_q;
	logic [7:0]  wd_q, rd_byte;
	logic        ws_q, wr_go, wr_ctrl, wr_data, flag_clr;
	logic        m_ev, m_stop_done, mst, m_tx, m_read, addr_ph, rep, arb_lost;
	logic        m_sda_low, m_scl_low, m_sample, drv_bit;
	logic        s_ev, s_sda_low, s_scl_low, s_copy, bus_busy;
	logic        addressed, s_tx, s_gc, mon_addr, mst_ack, own_hit, gc_hit, hit, s_want;
	logic [7:0]  mon_shift;

	two_flop_sync #(.W(2)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.d       ({scl_in, sda_in}),
		.q       (pin_s)
	);
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	// axi4-lite write: address and data taken in either order, one write at a time
	assign wr_go    = ~awready & ~wready & ~bvalid;
	assign wr_ctrl  = wr_go & ws_q & (aw_q == i2c_ctrl_pkg::ADDR_CTRL);
	assign wr_data  = wr_go & ws_q & (aw_q == i2c_ctrl_pkg::ADDR_DATA);
	assign flag_clr = wr_ctrl & wd_q[i2c_ctrl_pkg::CTL_FLAG];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= i2c_ctrl_pkg::RESP_OKAY;
			aw_q    <= 5'h00;
			wd_q    <= 8'h00;
			ws_q    <= 1'b0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_q    <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wd_q   <= wdata[7:0];
				ws_q   <= wstrb[0];
				wready <= 1'b0;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= (aw_q[1:0] == 2'b00 && aw_q <= i2c_ctrl_pkg::ADDR_LAST) ?
					i2c_ctrl_pkg::RESP_OKAY : i2c_ctrl_pkg::RESP_SLV;
			end else if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// axi4-lite read: answer in the second cycle after the address is taken
	always_comb begin
		case (ar_q)
			i2c_ctrl_pkg::ADDR_CTRL: rd_byte = {flag, ack_en, start_req, stop_req, wcol, enable, 1'b0, irq_en};
			i2c_ctrl_pkg::ADDR_STAT: rd_byte = status;
			i2c_ctrl_pkg::ADDR_DATA: rd_byte = data;
			i2c_ctrl_pkg::ADDR_OWN:  rd_byte = own_addr;
			i2c_ctrl_pkg::ADDR_ISTS: rd_byte = {4'h0, irq_sts};
			i2c_ctrl_pkg::ADDR_IMSK: rd_byte = {4'h0, irq_mask};
			i2c_ctrl_pkg::ADDR_HALF: rd_byte = half;
			default:                 rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= i2c_ctrl_pkg::RESP_OKAY;
			ar_q    <= 5'h00;
		end else if (ce) begin
			if (arvalid && arready) begin
				ar_q    <= araddr;
				arready <= 1'b0;
			end else if (!arready && !rvalid) begin
				rvalid <= 1'b1;
				rdata  <= {24'h00_0000, rd_byte};
				rresp  <= (ar_q[1:0] == 2'b00 && ar_q <= i2c_ctrl_pkg::ADDR_LAST) ?
					i2c_ctrl_pkg::RESP_OKAY : i2c_ctrl_pkg::RESP_SLV;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// software-owned control fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_en    <= i2c_ctrl_pkg::CTRL_RST[i2c_ctrl_pkg::CTL_ACK];
			start_req <= i2c_ctrl_pkg::CTRL_RST[i2c_ctrl_pkg::CTL_START];
			stop_req  <= i2c_ctrl_pkg::CTRL_RST[i2c_ctrl_pkg::CTL_STOP];
			enable    <= i2c_ctrl_pkg::CTRL_RST[i2c_ctrl_pkg::CTL_EN];
			irq_en    <= i2c_ctrl_pkg::CTRL_RST[i2c_ctrl_pkg::CTL_IE];
			own_addr  <= i2c_ctrl_pkg::OWN_RST;
			irq_mask  <= i2c_ctrl_pkg::IMSK_RST;
			half      <= i2c_ctrl_pkg::HALF_RST;
		end else if (ce) begin
			if (wr_ctrl) begin
				ack_en    <= wd_q[i2c_ctrl_pkg::CTL_ACK];
				start_req <= wd_q[i2c_ctrl_pkg::CTL_START];
				enable    <= wd_q[i2c_ctrl_pkg::CTL_EN];
				irq_en    <= wd_q[i2c_ctrl_pkg::CTL_IE];
			end
			// a software write outranks the hardware clear after a stop
			if (wr_ctrl)
				stop_req <= wd_q[i2c_ctrl_pkg::CTL_STOP];
			else if (m_stop_done)
				stop_req <= 1'b0;
			if (wr_go && ws_q && aw_q == i2c_ctrl_pkg::ADDR_OWN)
				own_addr <= wd_q;
			if (wr_go && ws_q && aw_q == i2c_ctrl_pkg::ADDR_IMSK)
				irq_mask <= wd_q[3:0];
			if (wr_go && ws_q && aw_q == i2c_ctrl_pkg::ADDR_HALF)
				half <= wd_q;
		end
	end

	// completion flag and status code; a new event wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag   <= 1'b0;
			status <= i2c_ctrl_pkg::ST_NONE;
		end else if (ce) begin
			if (m_ev) begin
				flag   <= 1'b1;
				status <= m_code;
			end else if (s_ev) begin
				flag   <= 1'b1;
				status <= s_code;
			end else if (flag_clr) begin
				flag   <= 1'b0;
				status <= i2c_ctrl_pkg::ST_NONE;
			end
		end
	end

	// data register: writes only while the flag holds the engine still
	assign s_copy = scl_fall & (mon_cnt == 4'd9) & ~mon_addr & addressed & ~s_tx & ~mst & enable;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data <= i2c_ctrl_pkg::DATA_RST;
			wcol <= 1'b0;
		end else if (ce) begin
			if (wr_data) begin
				wcol <= ~flag;
				if (flag)
					data <= wd_q;
			end else if (m_sample && !m_tx) begin
				data <= {data[6:0], sda_s};
			end else if (s_copy && !sleep_mode) begin
				data <= mon_shift;
			end
		end
	end

	// master sequencer
	assign m_sample = (state == st_high) & scl_s & (tmr == 8'h00) & (bit_cnt != 4'd8);
	assign drv_bit  = (bit_cnt == 4'd8) ? (~m_tx & ack_en) : (m_tx & ~data[3'd7 - bit_cnt[2:0]]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state       <= st_idle;
			tmr         <= 8'h00;
			bit_cnt     <= 4'h0;
			mst         <= 1'b0;
			m_tx        <= 1'b0;
			m_read      <= 1'b0;
			addr_ph     <= 1'b0;
			rep         <= 1'b0;
			arb_lost    <= 1'b0;
			m_sda_low   <= 1'b0;
			m_scl_low   <= 1'b0;
			m_ev        <= 1'b0;
			m_code      <= i2c_ctrl_pkg::ST_NONE;
			m_stop_done <= 1'b0;
		end else if (ce) begin
			m_ev        <= 1'b0;
			m_stop_done <= 1'b0;
			if (s_ev)
				arb_lost <= 1'b0;
			if (!enable) begin
				state     <= st_idle;
				mst       <= 1'b0;
				m_sda_low <= 1'b0;
				m_scl_low <= 1'b0;
			end else begin
				case (state)
					st_idle: begin
						m_sda_low <= 1'b0;
						m_scl_low <= 1'b0;
						if (start_req && !flag && !s_ev && !sleep_mode && !bus_busy && !addressed) begin
							state <= st_start;
							rep   <= 1'b0;
							tmr   <= half;
						end
					end
					st_rstart: begin
						if (tmr != 8'h00)
							tmr <= tmr - 8'd1;
						else begin
							m_scl_low <= 1'b0;
							state     <= st_start;
							tmr       <= half;
						end
					end
					st_start: begin
						if (!scl_s)
							tmr <= half;
						else if (tmr != 8'h00)
							tmr <= tmr - 8'd1;
						else if (!m_sda_low) begin
							m_sda_low <= 1'b1;
							tmr       <= half;
						end else begin
							m_scl_low <= 1'b1;
							mst       <= 1'b1;
							addr_ph   <= 1'b1;
							state     <= st_hold;
							m_ev      <= 1'b1;
							m_code    <= rep ? i2c_ctrl_pkg::ST_RSTART : i2c_ctrl_pkg::ST_START;
						end
					end
					st_hold: begin
						// bus clock stays low until software clears the flag
						if (!flag && !m_ev) begin
							tmr <= half;
							if (stop_req) begin
								state     <= st_stop;
								m_sda_low <= 1'b1;
							end else if (start_req) begin
								state     <= st_rstart;
								rep       <= 1'b1;
								m_sda_low <= 1'b0;
							end else begin
								state   <= st_low;
								bit_cnt <= 4'h0;
								m_tx    <= addr_ph | ~m_read;
								if (addr_ph)
									m_read <= data[0];
							end
						end else begin
							m_sda_low <= 1'b0;
						end
					end
					st_low: begin
						// sda moves mid-way through the low phase, clear of both clock edges
						if (tmr == {1'b0, half[7:1]})
							m_sda_low <= drv_bit;
						if (tmr != 8'h00)
							tmr <= tmr - 8'd1;
						else begin
							m_scl_low <= 1'b0;
							tmr       <= half;
							state     <= st_high;
						end
					end
					st_high: begin
						// a slave stretching the clock holds the count back
						if (!scl_s)
							tmr <= half;
						else if (tmr != 8'h00)
							tmr <= tmr - 8'd1;
						else if (m_tx && bit_cnt != 4'd8 && !m_sda_low && !sda_s) begin
							mst       <= 1'b0;
							arb_lost  <= 1'b1;
							m_scl_low <= 1'b0;
							state     <= st_idle;
						end else begin
							m_scl_low <= 1'b1;
							tmr       <= half;
							if (bit_cnt == 4'd8) begin
								state   <= st_hold;
								addr_ph <= 1'b0;
								m_ev    <= 1'b1;
								if (addr_ph)
									m_code <= m_read ? (sda_s ? i2c_ctrl_pkg::ST_AR_NACK : i2c_ctrl_pkg::ST_AR_ACK)
										: (sda_s ? i2c_ctrl_pkg::ST_AW_NACK : i2c_ctrl_pkg::ST_AW_ACK);
								else if (m_tx)
									m_code <= sda_s ? i2c_ctrl_pkg::ST_DW_NACK : i2c_ctrl_pkg::ST_DW_ACK;
								else
									m_code <= m_sda_low ? i2c_ctrl_pkg::ST_DR_ACK : i2c_ctrl_pkg::ST_DR_NACK;
							end else begin
								bit_cnt <= bit_cnt + 4'd1;
								state   <= st_low;
							end
						end
					end
					st_stop: begin
						if (m_scl_low) begin
							if (tmr != 8'h00)
								tmr <= tmr - 8'd1;
							else begin
								m_scl_low <= 1'b0;
								tmr       <= half;
							end
						end else if (!scl_s)
							tmr <= half;
						else if (tmr != 8'h00)
							tmr <= tmr - 8'd1;
						else begin
							m_sda_low   <= 1'b0;
							mst         <= 1'b0;
							state       <= st_idle;
							m_stop_done <= 1'b1;
						end
					end
					default: state <= st_idle;
				endcase
			end
		end
	end

	// slave side: watches every byte on the bus, master or not
	assign own_hit = (mon_shift[7:1] == own_addr[7:1]);
	assign gc_hit  = (mon_shift[7:1] == 7'h00) & own_addr[0];
	assign hit     = (own_hit | gc_hit) & ack_en & enable & ~mst;
	assign s_want  = addressed & s_tx & ~data[7];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_busy  <= 1'b0;
			mon_cnt   <= 4'h0;
			mon_shift <= 8'h00;
			mon_addr  <= 1'b0;
			addressed <= 1'b0;
			s_tx      <= 1'b0;
			s_gc      <= 1'b0;
			mst_ack   <= 1'b0;
			s_sda_low <= 1'b0;
			s_scl_low <= 1'b0;
			s_ev      <= 1'b0;
			s_code    <= i2c_ctrl_pkg::ST_NONE;
		end else if (ce) begin
			s_ev <= 1'b0;
			if (!enable) begin
				addressed <= 1'b0;
				mon_addr  <= 1'b0;
				s_sda_low <= 1'b0;
				s_scl_low <= 1'b0;
			end else if (start_det || stop_det) begin
				bus_busy  <= start_det;
				mon_cnt   <= 4'h0;
				mon_addr  <= start_det;
				s_sda_low <= 1'b0;
				addressed <= 1'b0;
				if (addressed && !s_tx) begin
					s_ev   <= 1'b1;
					s_code <= i2c_ctrl_pkg::ST_SR_STOP;
				end
			end else if (scl_rise) begin
				if (mon_cnt[3] == 1'b0)
					mon_shift <= {mon_shift[6:0], sda_s};
				else
					mst_ack <= ~sda_s;
				if (mon_cnt != 4'd9)
					mon_cnt <= mon_cnt + 4'd1;
			end else if (scl_fall) begin
				case (mon_cnt)
					4'd8: begin
						if (mon_addr) begin
							if (hit) begin
								addressed <= 1'b1;
								s_tx      <= mon_shift[0];
								s_gc      <= gc_hit & ~own_hit;
								s_sda_low <= 1'b1;
							end
						end else
							s_sda_low <= addressed & ~s_tx & ack_en;
					end
					4'd9: begin
						mon_cnt   <= 4'h0;
						mon_addr  <= 1'b0;
						s_sda_low <= 1'b0;
						if (mon_addr && addressed) begin
							s_ev      <= 1'b1;
							s_scl_low <= 1'b1;
							if (s_tx)
								s_code <= arb_lost ? i2c_ctrl_pkg::ST_SR_ARB : i2c_ctrl_pkg::ST_SR;
							else if (s_gc)
								s_code <= arb_lost ? i2c_ctrl_pkg::ST_GC_ARB : i2c_ctrl_pkg::ST_GC;
							else
								s_code <= arb_lost ? i2c_ctrl_pkg::ST_SW_ARB : i2c_ctrl_pkg::ST_SW;
						end else if (addressed && !mst) begin
							s_ev      <= 1'b1;
							s_scl_low <= 1'b1;
							if (s_tx) begin
								if (!mst_ack) begin
									s_code    <= i2c_ctrl_pkg::ST_ST_NACK;
									addressed <= 1'b0;
								end else if (!ack_en) begin
									s_code    <= i2c_ctrl_pkg::ST_ST_LAST;
									addressed <= 1'b0;
								end else
									s_code <= i2c_ctrl_pkg::ST_ST_ACK;
							end else begin
								if (s_gc)
									s_code <= s_sda_low ? i2c_ctrl_pkg::ST_GR_ACK : i2c_ctrl_pkg::ST_GR_NACK;
								else
									s_code <= s_sda_low ? i2c_ctrl_pkg::ST_SR_ACK : i2c_ctrl_pkg::ST_SR_NACK;
								if (!s_sda_low)
									addressed <= 1'b0;
							end
						end else if (arb_lost && !mst) begin
							s_ev   <= 1'b1;
							s_code <= i2c_ctrl_pkg::ST_ARB;
						end
					end
					default: s_sda_low <= addressed & s_tx & ~data[3'd7 - mon_cnt[2:0]];
				endcase
			end else if (s_scl_low && !flag && !s_ev) begin
				// first bit goes onto sda one cycle before the clock is let go
				s_sda_low <= s_want;
				if (s_sda_low == s_want)
					s_scl_low <= 1'b0;
			end
		end
	end

	// interrupt status: sticky, write one to clear, set wins
	assign irq_ev = {s_ev & arb_lost,
		s_ev & sleep_mode, wr_data & ~flag, m_ev | s_ev};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sts  <= 4'h0;
			wake_req <= 1'b0;
			irq      <= 1'b0;
			sda_oe_n <= 1'b1;
			scl_oe_n <= 1'b1;
			sda_out  <= 1'b0;
			scl_out  <= 1'b0;
		end else if (ce) begin
			if (wr_go && ws_q && aw_q == i2c_ctrl_pkg::ADDR_ISTS)
				irq_sts <= (irq_sts & ~wd_q[3:0]) | irq_ev;
			else
				irq_sts <= irq_sts | irq_ev;
			if (s_ev && sleep_mode)
				wake_req <= 1'b1;
			else if (!sleep_mode)
				wake_req <= 1'b0;
			irq      <= (|(irq_sts & irq_mask)) | (flag & irq_en);
			sda_oe_n <= ~(m_sda_low | s_sda_low);
			scl_oe_n <= ~(m_scl_low | s_scl_low);
			sda_out  <= 1'b0;
			scl_out  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: i2c_master_slave_ctrl_test.sv */
// self-checking bench for the two-wire controller
`timescale 1ns/100ps
`default_nettype none
module i2c_master_slave_ctrl_test;
	logic	aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, sleep_mode = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic	bready = 1'b0, arvalid = 1'b0, rready = 1'b0, a, p;
	logic [4:0]	awaddr = 5'h00, araddr = 5'h00;
	logic [31:0]	wdata = 32'h0000_0000, rdata, d;
	logic [1:0]	rresp, r, bresp, b;
	logic	awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, scl, sda, wake_req, irq;
	int	num_errors = 0, tests_run = 0;
	always #50 aclk = ~aclk;
	i2c_master_slave_ctrl i_dut (
		.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.scl_in(scl), .scl_out(), .scl_oe_n, .sda_in(sda), .sda_out(), .sda_oe_n, .sleep_mode, .wake_req, .irq
	);
	i2c_bus_peer i_peer (.dut_scl_oe_n(scl_oe_n), .dut_sda_oe_n(sda_oe_n), .scl, .sda);
	task automatic report_and_stop;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic tmo;
		num_errors++;
		report_and_stop();
	endtask
	task automatic rst;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [7:0] v);
		int n;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= {24'h00_0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		b = bresp;
		if (n == 99) tmo();
	endtask
	task automatic rc(input logic [4:0] ad, input logic [7:0] e);
		int n;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		r = rresp;
		chk("rdata", rdata, {24'h00_0000, e});
		if (n == 99) tmo();
	endtask
	// a stale high level from before the flag was cleared must not count
	task automatic wait_irq;
		int n;
		p = 1'b1;
		for (n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if (irq === 1'b1 && p === 1'b0) break;
			p = irq;
		end
		if (n == 3000) tmo();
	endtask
	task automatic t_regs;
		logic [4:0] ad [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h14, 5'h18, 5'h1C};
		logic [7:0] ev [7] = '{8'h00, 8'hF8, 8'hFF, 8'h00, 8'h00, 8'h04, 8'h00};
		rst();
		wr(5'h04, 8'h00);
		chk("bresp", b, 2'b00);
		wr(5'h1C, 8'h00);
		chk("bresp", b, 2'b10);
		for (int i = 0; i < 7; i++) begin
			rc(ad[i], ev[i]);
			chk("rresp", r, {i == 6, 1'b0});
		end
	endtask
	task automatic t_irq;
		rst();
		wr(5'h14, 8'h01);
		wr(5'h00, 8'hA4);
		// with the clock enable low the start must not get as far as holding scl
		ce <= 1'b0;
		repeat (40) @(posedge aclk);
		chk("frozen scl", scl_oe_n, 1'b1);
		ce <= 1'b1;
		wait_irq();
		rc(5'h10, 8'h01);
		wr(5'h10, 8'h01);
		rc(5'h10, 8'h00);
		chk("irq", irq, 1'b0);
		wr(5'h00, 8'h25);
		rc(5'h04, 8'h08);
		chk("irq", irq, 1'b1);
	endtask
	task automatic t_master(input logic ack);
		rst();
		i_peer.ack = ack;
		wr(5'h00, 8'hA5);
		wait_irq();
		rc(5'h04, 8'h08);
		wr(5'h08, 8'hA4);
		wr(5'h00, 8'h85);
		wait_irq();
		rc(5'h04, ack ? 8'h18 : 8'h20);
		if (ack) begin
			wr(5'h08, 8'h3C);
			wr(5'h00, 8'h85);
			wait_irq();
			rc(5'h04, 8'h28);
			chk("peer byte", i_peer.got, 8'h3C);
		end
	endtask
	task automatic t_slave;
		logic [7:0] ow [6] = '{8'hA5, 8'hA5, 8'hA4, 8'hA5, 8'hA5, 8'hA5};
		logic [7:0] ct [6] = '{8'h45, 8'h45, 8'h45, 8'h45, 8'h05, 8'h45};
		logic [7:0] by [6] = '{8'hA4, 8'h00, 8'h00, 8'hA5, 8'hA4, 8'hA4};
		logic [7:0] st [6] = '{8'h60, 8'h70, 8'hF8, 8'hA8, 8'hF8, 8'h60};
		for (int i = 0; i < 6; i++) begin
			rst();
			wr(5'h0C, ow[i]);
			wr(5'h00, ct[i]);
			sleep_mode <= i == 5;
			i_peer.xfer(by[i], a);
			repeat (20) @(posedge aclk);
			chk("ack", a, st[i] != 8'hF8);
			rc(5'h04, st[i]);
			chk("irq", irq, st[i] != 8'hF8);
			chk("wake", wake_req, i == 5);
			sleep_mode <= 1'b0;
			wr(5'h00, ct[i] | 8'h80);
			i_peer.stop(a);
			if (!a) tmo();
		end
	endtask
	initial begin
		t_regs();
		t_irq();
		t_master(1'b1);
		t_master(1'b0);
		t_slave();
		report_and_stop();
	end
endmodule
`default_nettype wire

/* File: two_flop_sync.sv */
// two-stage synchroniser for the bus pins
`timescale 1ns/100ps
`default_nettype none
module two_flop_sync #(
	parameter int W = 2
) (
	// clock
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// data
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta;

	// idle bus reads high, so both stages reset to ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '1;
			q    <= '1;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire
